// ==== src/sarpc_ctrl.sv ====
// Converter control and parallel host interface.
// Assumes strobe, select and strap pins are asynchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "sarpc_regs.svh"
module sarpc_ctrl
  import sarpc_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_conv_strobe_n,
  input  wire logic                  i_read_select,
  input  wire logic                  i_high_byte_select,
  input  wire logic                  i_reference_adjust_strap,
  input  wire logic                  i_cmp_above,
  output logic                       o_eoc_n,
  output sarpc_pkg::sarpc_result_t   o_result_wide,
  output logic [13:0]                o_result_wide_oe,
  output sarpc_pkg::sarpc_byte_t     o_result_byte,
  output logic [7:0]                 o_result_byte_oe,
  output logic                       o_powered,
  output logic                       o_tracking,
  output logic                       o_ref_on,
  output logic                       o_ext_ref
);
  import sarpc_pkg::*;

  localparam int CONV_CYCLES = `SARPC_CONV_CYCLES;
  localparam int STEP_DIV    = CONV_CYCLES / 16;

  sarpc_state_e  state;
  sarpc_state_e  next_state;
  logic [2:0]    cs_sync;
  logic [1:0]    rc_sync;
  logic [1:0]    hb_sync;
  logic [1:0]    strap_sync;
  logic          shutdown_after;
  logic [8:0]    step_cnt;
  logic          step_en;
  logic          sar_busy;
  logic          sar_busy_q;
  sarpc_result_t sar_result;
  sarpc_result_t held_result;

  // Two flops per pin; the third cs stage only feeds the edge detector.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_sync    <= 3'h7;
      rc_sync    <= 2'h0;
      hb_sync    <= 2'h0;
      strap_sync <= 2'h0;
    end else begin
      cs_sync    <= {cs_sync[1:0], i_conv_strobe_n};
      rc_sync    <= {rc_sync[0], i_read_select};
      hb_sync    <= {hb_sync[0], i_high_byte_select};
      strap_sync <= {strap_sync[0], i_reference_adjust_strap};
    end
  end

  // Falling edge seen on synchronised stages only.
  wire cs_fall   = cs_sync[2] & ~cs_sync[1];
  wire rc_level  = rc_sync[1];
  wire hb_level  = hb_sync[1];
  wire conv_done = sar_busy_q & ~sar_busy;
  wire start_conv = (state == SARPC_ACQUIRE) && cs_fall;

  // Sequencing by strobe edges, except convert to done on engine finish; a strobe with select high while asleep is ignored.
  always_comb begin
    next_state = state;
    unique case (state)
      SARPC_SLEEP:   if (cs_fall && !rc_level) next_state = SARPC_ACQUIRE;
      SARPC_ACQUIRE: if (cs_fall) next_state = SARPC_CONVERT;
      SARPC_CONVERT: if (conv_done) next_state = SARPC_DONE;
      SARPC_DONE:    if (cs_fall && rc_level) next_state = SARPC_READ;
      SARPC_READ:    if (cs_fall && !rc_level) next_state = SARPC_ACQUIRE;
      default:       next_state = SARPC_SLEEP;
    endcase
  end

  // State register; the reset input clears everything to sleep.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SARPC_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // Step divider spaces the 14 bit decisions one sixteenth of the conversion time apart.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      step_cnt <= 9'h000;
    end else if (start_conv || step_cnt == 9'(STEP_DIV - 1)) begin
      step_cnt <= 9'h000;
    end else begin
      step_cnt <= step_cnt + 9'h001;
    end
  end
  assign step_en = (step_cnt == 9'(STEP_DIV - 1));

  sarpc_sar_engine u_engine (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_start     (start_conv),
    .i_step      (step_en),
    .i_cmp_above (i_cmp_above),
    .o_busy      (sar_busy),
    .o_result    (sar_result)
  );

  // Power mode, result capture and status outputs, all registered.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sar_busy_q     <= 1'b0;
      shutdown_after <= 1'b1;
      held_result    <= '0;
      o_eoc_n        <= `SARPC_EOC_IDLE;
      o_powered      <= 1'b0;
      o_tracking     <= 1'b0;
      o_ref_on       <= 1'b0;
      o_ext_ref      <= 1'b0;
    end else begin
      sar_busy_q <= sar_busy;
      o_ext_ref  <= strap_sync[1];
      if (start_conv) begin
        shutdown_after <= rc_level;
      end
      if (conv_done) begin
        held_result <= sar_result;
      end
      if (next_state == SARPC_DONE) begin
        o_eoc_n <= 1'b0;
      end else if (next_state == SARPC_ACQUIRE || next_state == SARPC_CONVERT) begin
        o_eoc_n <= 1'b1;
      end
      o_tracking <= (next_state == SARPC_ACQUIRE);
      o_powered  <= (next_state != SARPC_SLEEP);
      if (next_state == SARPC_ACQUIRE) begin
        o_ref_on <= 1'b1;
      end else if (conv_done && shutdown_after) begin
        o_ref_on <= 1'b0;
      end
    end
  end

  // Bus drive: the byte lane follows the high-byte select while reading.
  wire           reading   = (next_state == SARPC_READ);
  sarpc_byte_t   byte_pick;
  assign byte_pick = hb_level ? sarpc_byte_t'(held_result >> `SARPC_HIGH_BYTE_LSB)
                              : held_result[7:0];

  // Output enables rise only in the read state; the bus floats otherwise.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_result_wide    <= '0;
      o_result_wide_oe <= 14'h0000;
      o_result_byte    <= 8'h00;
      o_result_byte_oe <= 8'h00;
    end else begin
      o_result_wide    <= held_result;
      o_result_byte    <= byte_pick;
      o_result_wide_oe <= {14{reading}};
      o_result_byte_oe <= {8{reading}};
    end
  end

  // Checks on the sequencing, the bus drive and the reference outputs.
  chk_bus_float_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state != SARPC_READ) |-> (o_result_wide_oe == 14'h0000))
    else $error("Data bus driven outside a read.");
  chk_read_drives: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == SARPC_DONE && cs_fall && rc_level) |=> ##1 (o_result_byte_oe == 8'hff))
    else $error("Read strobe did not drive the bus.");
  chk_acquire_entry: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == SARPC_SLEEP && cs_fall && !rc_level) |=> o_tracking)
    else $error("First strobe did not start acquisition.");
  chk_sleep_ignore: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state == SARPC_SLEEP && cs_fall && rc_level) |=> (state == SARPC_SLEEP))
    else $error("Strobe with select high left sleep.");
  chk_conv_start: assert property (@(posedge i_core_clk) disable iff (i_rst)
    start_conv |=> (sar_busy && state == SARPC_CONVERT))
    else $error("Second strobe did not start conversion.");
  chk_eoc_time: assert property (@(posedge i_core_clk) disable iff (i_rst)
    start_conv |-> ##[1:470] !o_eoc_n)
    else $error("Conversion exceeded its time.");
  chk_high_byte: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (hb_level && reading) |=> (o_result_byte == {2'b00, $past(held_result[13:8])}))
    else $error("High byte wrong.");
  chk_low_byte: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!hb_level && reading) |=> (o_result_byte == $past(held_result[7:0])))
    else $error("Low byte wrong.");
  chk_ref_shutdown: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (conv_done && shutdown_after) |=> !o_ref_on)
    else $error("Reference stayed on after shutdown conversion.");
  chk_ext_ref: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_ext_ref == $past(strap_sync[1]))
    else $error("Reference mode not following strap.");
  chk_reset_state: assert property (@(posedge i_core_clk)
    i_rst |=> (state == SARPC_SLEEP && o_eoc_n))
    else $error("Reset did not restore sleep.");

  cov_full_cycle: cover property (@(posedge i_core_clk) disable iff (i_rst)
    (state == SARPC_DONE) ##1 (state == SARPC_READ));
  cov_standby: cover property (@(posedge i_core_clk) disable iff (i_rst)
    conv_done && !shutdown_after);
  cov_shutdown: cover property (@(posedge i_core_clk) disable iff (i_rst)
    conv_done && shutdown_after);
  cov_high_read: cover property (@(posedge i_core_clk) disable iff (i_rst)
    reading && hb_level);
endmodule : sarpc_ctrl
`default_nettype wire

// ==== src/sarpc_pkg.sv ====
// Types shared by the converter control block.
// Assumes sarpc_regs.svh is on the include path.
`include "sarpc_regs.svh"
package sarpc_pkg;
  typedef logic [`SARPC_RESULT_W-1:0] sarpc_result_t;
  typedef logic [`SARPC_BYTE_W-1:0]   sarpc_byte_t;
  typedef enum logic [2:0] {
    SARPC_SLEEP   = 3'b000,
    SARPC_ACQUIRE = 3'b001,
    SARPC_CONVERT = 3'b010,
    SARPC_DONE    = 3'b011,
    SARPC_READ    = 3'b100
  } sarpc_state_e;
endpackage : sarpc_pkg

// ==== src/sarpc_regs.svh ====
// Timing counts and field layout for the converter control block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef SARPC_REGS_SVH
`define SARPC_REGS_SVH
`define SARPC_CLK_PERIOD_NS 10
`define SARPC_RESULT_W 14
`define SARPC_BYTE_W 8
`define SARPC_HIGH_BYTE_LSB 8
`define SARPC_CONV_TIME_NS 4700
`define SARPC_CONV_CYCLES (`SARPC_CONV_TIME_NS / `SARPC_CLK_PERIOD_NS)
`define SARPC_EOC_IDLE 1'b1
`endif

// ==== src/sarpc_sar_engine.sv ====
// Successive-approximation engine: one result bit per step.
// Assumes a start pulse and a comparator input on the core clock.
`timescale 1ns/1ns
`default_nettype none
module sarpc_sar_engine
  import sarpc_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_start,
  input  wire logic              i_step,
  input  wire logic              i_cmp_above,
  output logic                   o_busy,
  output sarpc_pkg::sarpc_result_t o_result
);
  logic [3:0]    bit_idx;
  sarpc_result_t trial;

  // Each step keeps or drops the trial bit, then tries the next lower one; the bit 0 step stores the result instead.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_idx  <= 4'h0;
      trial    <= '0;
      o_result <= '0;
      o_busy   <= 1'b0;
    end else if (i_start) begin
      bit_idx <= 4'hd;
      trial   <= 14'h2000;
      o_busy  <= 1'b1;
    end else if (o_busy && i_step) begin
      if (bit_idx == 4'h0) begin
        o_busy   <= 1'b0;
        o_result <= i_cmp_above ? trial : (trial & ~14'h0001);
      end else begin
        trial   <= (i_cmp_above ? trial : (trial & ~(14'h0001 << bit_idx))) | (14'h0001 << (bit_idx - 4'h1));
        bit_idx <= bit_idx - 4'h1;
      end
    end
  end
endmodule : sarpc_sar_engine
`default_nettype wire

// ==== verification/sarpc_ctrl_tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes the host model file and the design sources are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define SARPC_CHK(a, b, m) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t %s", $time, m); end end
module sarpc_ctrl_tb_top;
  import sarpc_pkg::*;
  logic                    i_core_clk;
  logic                    i_rst;
  logic                    i_cmp_above;
  logic                    strap;
  sarpc_pkg::sarpc_result_t sample_level;
  wire logic               strobe_n;
  wire logic               rd_sel;
  wire logic               hb_sel;
  logic                    eoc_n;
  sarpc_pkg::sarpc_result_t wide;
  logic [13:0]             wide_oe;
  sarpc_pkg::sarpc_byte_t  lane;
  logic [7:0]              lane_oe;
  logic                    powered;
  logic                    tracking;
  logic                    ref_on;
  logic                    ext_ref;
  int                      bad_count;
  int                      checks;
  int                      cyc;

  sarpc_host_model host (.i_core_clk(i_core_clk), .o_conv_strobe_n(strobe_n), .o_read_select(rd_sel),
    .o_high_byte_select(hb_sel));
  sarpc_ctrl dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_conv_strobe_n(strobe_n), .i_read_select(rd_sel),
    .i_high_byte_select(hb_sel), .i_reference_adjust_strap(strap), .i_cmp_above(i_cmp_above),
    .o_eoc_n(eoc_n), .o_result_wide(wide), .o_result_wide_oe(wide_oe), .o_result_byte(lane),
    .o_result_byte_oe(lane_oe), .o_powered(powered), .o_tracking(tracking), .o_ref_on(ref_on),
    .o_ext_ref(ext_ref));

  // Free-running 100 MHz core clock.
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Comparator model: the held sample against the engine's trial code.
  // It settles at the falling edge, well before the next step samples it.
  always @(negedge i_core_clk) begin
    i_cmp_above = (sample_level >= dut.u_engine.trial);
  end

  // Watchdog: two conversions and one aborted by reset need well under this many cycles.
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // Reset leaves the bus floating, end-of-conversion idle and the device asleep.
  task automatic t_reset();
    @(negedge i_core_clk) i_rst = 1'b1;
    repeat (12) @(negedge i_core_clk);
    `SARPC_CHK(wide_oe, 14'h0000, "wide oe in reset")
    `SARPC_CHK({lane_oe, eoc_n, powered}, 10'h002, "status in reset")
    i_rst = 1'b0;
    @(negedge i_core_clk);
  endtask : t_reset

  // A strobe with read select high while asleep must not wake the device.
  task automatic t_refused();
    host.strobe(1'b1);
    repeat (4) @(negedge i_core_clk);
    `SARPC_CHK(powered, 1'b0, "woke on read strobe")
  endtask : t_refused

  // Full acquire, convert and read cycle; the sampled level is the expected code.
  task automatic t_convert(input sarpc_result_t lvl, input logic sel2);
    sarpc_result_t exp;
    int            n;
    exp = lvl;
    sample_level = lvl;
    host.strobe(1'b0);
    `SARPC_CHK({powered, tracking}, 2'b11, "no acquisition")
    host.strobe(sel2);
    `SARPC_CHK(tracking, 1'b0, "still tracking")
    n = 0;
    while (eoc_n !== 1'b0 && n < 700) begin
      @(negedge i_core_clk);
      n++;
    end
    `SARPC_CHK(eoc_n, 1'b0, "no end of conversion")
    `SARPC_CHK(wide_oe, 14'h0000, "bus driven before read")
    repeat (3) @(negedge i_core_clk);
    `SARPC_CHK(ref_on, ~sel2, "reference power mode")
    host.strobe(1'b0);
    `SARPC_CHK({wide_oe[0], eoc_n, tracking}, 3'b000, "read strobe with select low")
    host.strobe(1'b1);
    `SARPC_CHK(wide_oe, 14'h3fff, "wide bus not driven")
    `SARPC_CHK(wide, exp, "wide result")
    host.pick_byte(1'b1);
    repeat (5) @(negedge i_core_clk);
    `SARPC_CHK({lane_oe, lane}, {8'hff, 2'b00, exp[13:8]}, "upper byte")
    host.pick_byte(1'b0);
    repeat (5) @(negedge i_core_clk);
    `SARPC_CHK(lane, exp[7:0], "lower byte")
  endtask : t_convert

  // Strap level picks the reference source; a reset mid-conversion aborts it.
  task automatic t_strap_abort();
    strap = 1'b1;
    repeat (5) @(negedge i_core_clk);
    `SARPC_CHK(ext_ref, 1'b1, "external reference")
    host.strobe(1'b0);
    host.strobe(1'b0);
    t_reset();
    repeat (3) @(negedge i_core_clk);
    `SARPC_CHK({powered, eoc_n, ext_ref}, 3'b011, "abort state")
    strap = 1'b0;
    repeat (5) @(negedge i_core_clk);
    `SARPC_CHK(ext_ref, 1'b0, "internal reference")
  endtask : t_strap_abort

  // Main sequence; inputs start at known levels at time zero.
  initial begin
    i_rst        = 1'b1;
    sample_level = 14'h0000;
    strap        = 1'b0;
    t_reset();
    t_refused();
    t_convert(14'h2a5c, 1'b0);
    t_convert(14'h15a3, 1'b1);
    t_strap_abort();
    final_report();
  end
endmodule : sarpc_ctrl_tb_top
`undef SARPC_CHK
`default_nettype wire

// ==== verification/sarpc_host_model.sv ====
// Host side model: drives the convert strobe, read select and byte select.
// Assumes the bench calls its tasks and that all pins change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module sarpc_host_model (
  input  wire logic i_core_clk,
  output logic      o_conv_strobe_n,
  output logic      o_read_select,
  output logic      o_high_byte_select
);
  // Idle bus: strobe high, convert selected, lower byte chosen.
  initial begin
    o_conv_strobe_n    = 1'b1;
    o_read_select      = 1'b0;
    o_high_byte_select = 1'b0;
  end

  // Select settles a cycle before the fall and holds until the strobe is high again.
  task automatic strobe(input logic sel);
    @(negedge i_core_clk) o_read_select = sel;
    @(negedge i_core_clk) o_conv_strobe_n = 1'b0;
    repeat (4) @(negedge i_core_clk);
    o_conv_strobe_n = 1'b1;
    @(negedge i_core_clk);
  endtask : strobe

  // Byte select is a plain level; the host moves it only between strobes.
  task automatic pick_byte(input logic hi);
    @(negedge i_core_clk) o_high_byte_select = hi;
  endtask : pick_byte
endmodule : sarpc_host_model
`default_nettype wire
